/* core/xdma_channel.sv */
// one external-bus dma channel: normal mode, byte size, dual address, offset addition
// assumes synchronous request pin, memory bus answering with a one-cycle ack
//
// The address map and the Avalon-MM register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "xdma_map.svh"

module xdma_channel (
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire logic [7:0]                avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output var  logic [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  input  wire logic                      ext_transfer_request_n,
  output var  xdma_pkg::xdma_bus_req_type mem_out,
  input  wire logic [7:0]                mem_rdata,
  input  wire logic                      mem_ack,
  output logic                           irq
);
  import xdma_pkg::*;

  logic [31:0]    ctrl;
  logic [31:0]    src;
  logic [31:0]    dst;
  logic [31:0]    count;
  logic [31:0]    offset;
  logic           end_flag;
  logic           end_mask;
  logic           rd_ack;
  logic           req_prev;
  logic           pending;
  xdma_state_type state;
  logic           wr_acc;
  logic           rd_acc;
  logic           unit_done;
  logic           req_fall;

  // merge write data into a register under the byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        old[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return old;
  endfunction

  // writes take no wait state; reads wait one cycle so read data comes from a flop
  assign avs_waitrequest = avs_read & ~rd_ack;
  assign wr_acc    = avs_write;
  assign rd_acc    = avs_read & rd_ack;
  assign unit_done = (state == XDMA_WRITE) & mem_ack;
  assign req_fall  = req_prev & ~ext_transfer_request_n;
  assign irq       = end_flag & end_mask;

  // read path: one wait cycle, data registered, unmapped reads return zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_ack       <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      rd_ack <= avs_read & ~rd_ack;
      if (avs_read & ~rd_ack) begin
        unique case (avs_address)
          `XDMA_ADDR_CTRL:   avs_readdata <= ctrl;
          `XDMA_ADDR_SRC:    avs_readdata <= src;
          `XDMA_ADDR_DST:    avs_readdata <= dst;
          `XDMA_ADDR_COUNT:  avs_readdata <= count;
          `XDMA_ADDR_OFFSET: avs_readdata <= offset;
          `XDMA_ADDR_STATUS: avs_readdata <= {31'h0000_0000, end_flag};
          `XDMA_ADDR_MASK:   avs_readdata <= {31'h0000_0000, end_mask};
          default:           avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // control word; hardware clears enable when the count runs out, which beats a software write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= `XDMA_CTRL_RST;
    end else begin
      if (wr_acc && avs_address == `XDMA_ADDR_CTRL) begin
        ctrl <= merge(ctrl, avs_writedata, avs_byteenable) & 32'h8000_0007;
      end
      if (unit_done && count == 32'h0000_0001) begin
        ctrl[`XDMA_CTRL_ENABLE] <= 1'b0;
      end
    end
  end

  // addresses: software loads them, each finished byte steps them by the offset or leaves them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      src <= 32'h0000_0000;
      dst <= 32'h0000_0000;
    end else if (unit_done) begin
      if (ctrl[`XDMA_CTRL_SRCOFS]) begin
        src <= src + offset;
      end
      if (ctrl[`XDMA_CTRL_DSTOFS]) begin
        dst <= dst + offset;
      end
    end else begin
      if (wr_acc && avs_address == `XDMA_ADDR_SRC) begin
        src <= merge(src, avs_writedata, avs_byteenable);
      end
      if (wr_acc && avs_address == `XDMA_ADDR_DST) begin
        dst <= merge(dst, avs_writedata, avs_byteenable);
      end
    end
  end

  // count and offset; zero count wraps through all 2^32 bytes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count  <= `XDMA_COUNT_RST;
      offset <= `XDMA_OFFSET_RST;
    end else begin
      if (unit_done) begin
        count <= count - 32'h0000_0001;
      end else if (wr_acc && avs_address == `XDMA_ADDR_COUNT) begin
        count <= merge(count, avs_writedata, avs_byteenable);
      end
      if (wr_acc && avs_address == `XDMA_ADDR_OFFSET) begin
        offset <= merge(offset, avs_writedata, avs_byteenable);
      end
    end
  end

  // sticky end flag: a read of status clears it, a same-cycle set wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      end_flag <= 1'b0;
      end_mask <= 1'b0;
    end else begin
      if (unit_done && count == 32'h0000_0001) begin
        end_flag <= 1'b1;
      end else if (rd_acc && avs_address == `XDMA_ADDR_STATUS) begin
        end_flag <= 1'b0;
      end
      if (wr_acc && avs_address == `XDMA_ADDR_MASK && avs_byteenable[0]) begin
        end_mask <= avs_writedata[`XDMA_STAT_END];
      end
    end
  end

  // request capture: edges before enable are ignored; in auto mode the channel asks itself
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      req_prev <= 1'b1;
      pending  <= 1'b0;
    end else begin
      req_prev <= ext_transfer_request_n;
      if (!ctrl[`XDMA_CTRL_ENABLE]) begin
        pending <= 1'b0;
      end else if (!ctrl[`XDMA_CTRL_EXTREQ] || req_fall) begin
        pending <= 1'b1;
      end else if (state == XDMA_IDLE) begin
        pending <= 1'b0;
      end
    end
  end

  // cycle-steal sequencer: read one byte, write it, drop the bus for a cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state     <= XDMA_IDLE;
      mem_out   <= '0;
    end else begin
      unique case (state)
        XDMA_IDLE: begin
          if (pending && ctrl[`XDMA_CTRL_ENABLE]) begin
            state   <= XDMA_READ;
            mem_out <= '{req: 1'b1, we: 1'b0, addr: src, wdata: 8'h00};
          end
        end
        XDMA_READ: begin
          if (mem_ack) begin
            state     <= XDMA_WRITE;
            mem_out   <= '{req: 1'b1, we: 1'b1, addr: dst, wdata: mem_rdata};
          end
        end
        XDMA_WRITE: begin
          if (mem_ack) begin
            state   <= XDMA_IDLE;
            mem_out <= '0;
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_read_done;
    state == XDMA_READ && mem_ack;
  endsequence
  sequence s_write_issued;
    // the write must carry the byte just read to the destination loaded before it
    mem_out.req && mem_out.we && mem_out.addr == $past(dst) && mem_out.wdata == $past(mem_rdata);
  endsequence

  property p_edge_pending;
    req_fall && ctrl[`XDMA_CTRL_ENABLE] && ctrl[`XDMA_CTRL_EXTREQ] |=> pending;
  endproperty
  a_edge_pending: assert property (p_edge_pending) else $error("request edge not latched");
  property p_pending_starts;
    state == XDMA_IDLE && pending && ctrl[`XDMA_CTRL_ENABLE] |=> state == XDMA_READ && mem_out.req && !mem_out.we;
  endproperty
  a_pending_starts: assert property (p_pending_starts) else $error("pending request not started");
  property p_disabled_idle;
    !ctrl[`XDMA_CTRL_ENABLE] && state == XDMA_IDLE |=> state == XDMA_IDLE;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("transfer without enable");
  property p_read_then_write;
    s_read_done |=> s_write_issued;
  endproperty
  a_read_then_write: assert property (p_read_then_write) else $error("write did not follow read");
  property p_bus_released;
    unit_done |=> !mem_out.req && state == XDMA_IDLE;
  endproperty
  a_bus_released: assert property (p_bus_released) else $error("bus not released");
  property p_src_step;
    unit_done |=> src == $past(src) + ($past(ctrl[`XDMA_CTRL_SRCOFS]) ? $past(offset) : 32'h0000_0000);
  endproperty
  a_src_step: assert property (p_src_step) else $error("source step wrong");
  property p_dst_step;
    unit_done |=> dst == $past(dst) + ($past(ctrl[`XDMA_CTRL_DSTOFS]) ? $past(offset) : 32'h0000_0000);
  endproperty
  a_dst_step: assert property (p_dst_step) else $error("destination step wrong");
  property p_count_end;
    unit_done && count == 32'h0000_0001 |=> end_flag && !ctrl[`XDMA_CTRL_ENABLE] && count == 32'h0000_0000;
  endproperty
  a_count_end: assert property (p_count_end) else $error("count expiry missed");
  property p_flag_sticky;
    end_flag && !(rd_acc && avs_address == `XDMA_ADDR_STATUS) |=> end_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("end flag lost");
  property p_flag_cause;
    !end_flag && !(unit_done && count == 32'h0000_0001) |=> !end_flag;
  endproperty
  a_flag_cause: assert property (p_flag_cause) else $error("end flag set without cause");
endmodule // xdma_channel
`default_nettype wire

/* core/xdma_map.svh */
// register map, field positions and reset values of the dma channel
// assumes a 32-bit avalon-mm slave with byte addresses, one aligned word per register
`ifndef XDMA_MAP_SVH
`define XDMA_MAP_SVH

`define XDMA_ADDR_CTRL   8'h00
`define XDMA_ADDR_SRC    8'h04
`define XDMA_ADDR_DST    8'h08
`define XDMA_ADDR_COUNT  8'h0C
`define XDMA_ADDR_OFFSET 8'h10
`define XDMA_ADDR_STATUS 8'h14
`define XDMA_ADDR_MASK   8'h18

`define XDMA_CTRL_ENABLE 31
`define XDMA_CTRL_EXTREQ 2
`define XDMA_CTRL_SRCOFS 1
`define XDMA_CTRL_DSTOFS 0
`define XDMA_STAT_END    0

`define XDMA_CTRL_RST    32'h0000_0004
`define XDMA_OFFSET_RST  32'h0000_0002
`define XDMA_COUNT_RST   32'h0000_0080

`endif

/* core/xdma_pkg.sv */
// types shared by the dma channel and its surroundings
// assumes the map header supplies all numeric constants
package xdma_pkg;
  // one request on the external memory bus
  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [7:0]  wdata;
  } xdma_bus_req_type;

  typedef enum logic [1:0] {
    XDMA_IDLE,
    XDMA_READ,
    XDMA_WRITE
  } xdma_state_type;
endpackage

/* tb/xdma_mem_model.sv */
// memory partner: byte-wide external memory on the channel's bus
// assumes each request is held until ack; slow adds wait cycles
`timescale 1ns/100ps
`default_nettype none
module xdma_mem_model (
  input  wire logic                       clk,
  input  wire logic                       rstn,
  input  wire logic                       slow,
  input  wire xdma_pkg::xdma_bus_req_type mem_out,
  output var  logic [7:0]                 mem_rdata,
  output var  logic                       mem_ack
);
  import xdma_pkg::*;
  logic [7:0] mem [logic [31:0]];
  int         reads = 0;
  int         writes = 0;
  int         wait_cnt;
  // one ack pulse per held request; read and write are separate cycles
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 8'h5A;
      wait_cnt <= 0;
    end else begin
      mem_rdata <= ~mem_rdata; // data not answered keeps toggling
      mem_ack <= 1'b0;
      wait_cnt <= 0;
      if (mem_out.req && !mem_ack) begin
        wait_cnt <= wait_cnt + 1;
        if (wait_cnt >= (slow ? 3 : 0)) begin
          wait_cnt <= 0;
          mem_ack <= 1'b1;
          if (mem_out.we) begin
            mem[mem_out.addr] = mem_out.wdata;
            writes++;
          end else begin
            mem_rdata <= mem_out.addr[7:0] ^ mem_out.addr[15:8] ^ 8'hA5;
            reads++;
          end
        end
      end
    end
  end
endmodule // xdma_mem_model
`default_nettype wire

/* tb/tb_top.sv */
// top bench: register traffic, request edges and byte copies checked
// assumes the channel and the memory partner are compiled before it
`timescale 1ns/100ps
`default_nettype none
`include "xdma_map.svh"
module tb_top;
  import xdma_pkg::*;
  logic             clk = 1'b0;
  logic             rstn = 1'b0;
  logic [7:0]       adr = 8'h00;
  logic             rd = 1'b0;
  logic             wr = 1'b0;
  logic [31:0]      wd = 32'h0;
  logic [31:0]      rdat;
  logic             wreq;
  logic             req_n = 1'b1;
  logic             slow = 1'b0;
  xdma_bus_req_type mreq;
  logic [7:0]       mrd;
  logic             mack;
  logic             irq;
  logic [31:0]      lfsr = 32'h52;
  logic [31:0]      q;
  int               err_count = 0;
  int               total_checks = 0;
  localparam logic [31:0] RST_VAL [8] = '{32'h4, 32'h0, 32'h0, 32'h80, 32'h2, 32'h0, 32'h0, 32'h0};
  always #4 clk = ~clk;
  xdma_channel dut (.clk(clk), .rstn(rstn), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .ext_transfer_request_n(req_n), .mem_out(mreq), .mem_rdata(mrd), .mem_ack(mack), .irq(irq));
  xdma_mem_model mdl (.clk(clk), .rstn(rstn), .slow(slow), .mem_out(mreq), .mem_rdata(mrd),
    .mem_ack(mack));
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic logic [7:0] exp_byte(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one bus cycle: raised after a rising edge, held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (wreq !== 1'b0) begin
      err_count++;
      final_report();
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic fall();
    @(posedge clk);
    req_n <= 1'b0;
    repeat (2) @(posedge clk);
    req_n <= 1'b1;
  endtask
  task automatic wait_wr(input int target);
    for (int n = 0; n < 2000 && mdl.writes < target; n++) @(posedge clk);
    if (mdl.writes < target) begin
      err_count++;
      final_report();
    end
  endtask
  initial begin
    logic [31:0] src, dst, ofs, sa, da;
    int base;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    // reset values, the last word unmapped
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, 8'(i * 4), 32'h0);
      check(q, RST_VAL[i]);
    end
    bus(1'b1, `XDMA_ADDR_COUNT, 32'hFFFFFFFF);
    bus(1'b0, `XDMA_ADDR_COUNT, 32'h0);
    check(q, 32'hFFFFFFFF);
    $display("reset and count test done");
    // an edge that arrives while disabled must be forgotten
    fall();
    bus(1'b1, `XDMA_ADDR_CTRL, 32'h80000004);
    repeat (20) @(posedge clk);
    check(mdl.writes, 32'h0);
    bus(1'b0, `XDMA_ADDR_CTRL, 32'h0);
    check(q, 32'h80000004);
    $display("early edge test done");
    // every offset mode, prompt and slow memory, last mode masked
    for (int m = 0; m < 4; m++) begin
      slow <= m[0];
      src = rnd();
      dst = rnd();
      ofs = (rnd() & 32'h1E) + 32'h2;
      base = mdl.writes;
      bus(1'b1, `XDMA_ADDR_SRC, src);
      bus(1'b1, `XDMA_ADDR_DST, dst);
      bus(1'b1, `XDMA_ADDR_OFFSET, ofs);
      bus(1'b1, `XDMA_ADDR_COUNT, 32'h3);
      bus(1'b1, `XDMA_ADDR_MASK, {31'h0, m != 3});
      bus(1'b1, `XDMA_ADDR_CTRL, 32'h80000004 | m);
      for (int i = 0; i < 3; i++) begin
        fall();
        wait_wr(base + i + 1);
        sa = src + (m[1] ? i * ofs : 0);
        da = dst + (m[0] ? i * ofs : 0);
        check(mdl.mem[da], exp_byte(sa));
        check(mdl.reads, mdl.writes);
      end
      repeat (4) @(posedge clk);
      check(mdl.writes, base + 3);
      check(irq, m != 3);
      bus(1'b0, `XDMA_ADDR_STATUS, 32'h0);
      check(q, 32'h1);
      @(negedge clk);
      check(irq, 32'h0);
      bus(1'b0, `XDMA_ADDR_CTRL, 32'h0);
      check(q[31], 32'h0);
      bus(1'b0, `XDMA_ADDR_STATUS, 32'h0);
      check(q, 32'h0);
      $display("offset mode %0d test done", m);
    end
    // reference copy: 128 bytes, both addresses stepped by 2, the channel asking for itself
    src = rnd();
    dst = rnd();
    base = mdl.writes;
    bus(1'b1, `XDMA_ADDR_SRC, src);
    bus(1'b1, `XDMA_ADDR_DST, dst);
    bus(1'b1, `XDMA_ADDR_OFFSET, 32'h2);
    bus(1'b1, `XDMA_ADDR_COUNT, 32'h80);
    bus(1'b1, `XDMA_ADDR_CTRL, 32'h80000003);
    wait_wr(base + 128);
    repeat (8) @(posedge clk);
    check(mdl.writes, base + 128);
    for (int i = 0; i < 128; i += 37) begin
      check(mdl.mem[dst + i * 2], exp_byte(src + i * 2));
    end
    bus(1'b0, `XDMA_ADDR_COUNT, 32'h0);
    check(q, 32'h0);
    bus(1'b0, `XDMA_ADDR_STATUS, 32'h0);
    check(q, 32'h1);
    bus(1'b0, `XDMA_ADDR_CTRL, 32'h0);
    check(q, 32'h00000003);
    $display("reference copy test done");
    final_report();
  end
endmodule // tb_top
`default_nettype wire
